// File: src/rxqhf_regs.vh
// Register map, field positions and reset values of the queue count and hash filter block
// Notes on behaviour
// - The upper byte of the frame count register reads the number of frames held when the receive flag was raised.
// - Software clears the receive flag by writing one, and the reported frame count is refreshed with that clear.
// - The low byte of the frame count register is a writable threshold that resets to zero.
// - With threshold enable set, the receive flag is set once the held frame count exceeds the threshold.
// - With the space monitor set, the space-available flag is raised once free transmit space reaches the request.
// - A CRC over the full destination address gives a six-bit index into a 64-bit hash table.
// - The top two index bits pick one of four 16-bit table words and the lower four pick the bit.
// - The hash lookup applies only in the hash-perfect filtering mode, code 5.
// - A set table bit accepts the frame.
// - A clear table bit discards a multicast frame; unicast frames are always accepted.
// - Accept-all or accept-multicast enable accepts every multicast frame regardless of the table.
// - The receive flag is edge-set when a frame is ready and cleared by writing one.
`ifndef RXQHF_REGS_VH
`define RXQHF_REGS_VH
`define RXQHF_OFS_FCOUNT 8'h9c
`define RXQHF_OFS_TXREQ 8'h9e
`define RXQHF_OFS_HASH0 8'ha0
`define RXQHF_OFS_HASH1 8'ha2
`define RXQHF_OFS_HASH2 8'ha4
`define RXQHF_OFS_HASH3 8'ha6
`define RXQHF_OFS_STATUS 8'h92
`define RXQHF_RST_FCOUNT 16'h0000
`define RXQHF_RST_COUNT 8'h00
`define RXQHF_RST_THRESH 8'h00
`define RXQHF_RST_TXREQ 16'h0000
`define RXQHF_RST_HASH 16'h0000
`define RXQHF_BIT_RXFLAG 13
`define RXQHF_BIT_TXFLAG 6
`define RXQHF_MODE_HASH 3'h5
`define RXQHF_CRC_POLY 32'h04c1_1db7
`define RXQHF_CRC_INIT 32'hffff_ffff
`endif

// File: src/rxqhf_core.v
// Frame count, transmit space request and multicast hash filter block
`timescale 1ns/1ps
`include "rxqhf_regs.vh"
module rxqhf_core #(
    parameter CNT_W = 8,
    parameter SPACE_W = 16
) (
    input wire clk_sys,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [CNT_W-1:0] rx_frames_held,
    input wire rx_frame_ready,
    input wire threshold_enable,
    input wire mem_monitor_enable,
    input wire [SPACE_W-1:0] tx_free_space,
    input wire [2:0] filter_mode,
    input wire accept_all_enable,
    input wire accept_multicast_enable,
    input wire da_valid,
    input wire [47:0] da_addr,
    output reg da_done,
    output reg da_accept,
    output reg da_drop,
    output wire rx_flag,
    output wire tx_space_flag,
    output wire [SPACE_W-1:0] tx_space_request
);

    // Captured count, threshold and transmit request
    reg [7:0] rx_frame_count_r;
    reg [7:0] rx_frame_count_nxt;
    reg [7:0] rx_frame_threshold_r;
    reg [15:0] tx_next_frames_size_r;

    // Table words; word n holds table bits 16n to 16n+15
    reg [15:0] hash_word0_r;
    reg [15:0] hash_word1_r;
    reg [15:0] hash_word2_r;
    reg [15:0] hash_word3_r;
    wire [63:0] hash_table;

    // Sticky status flags and their next values
    reg rx_flag_r;
    reg rx_flag_nxt;
    reg tx_flag_r;
    reg tx_flag_nxt;

    // Delayed set levels for the edge detectors
    reg rx_set_d_r;
    reg space_ok_d_r;

    // Read data next value
    reg [15:0] rdata_nxt;

    // Filter verdict next values
    reg da_accept_nxt;
    reg da_drop_nxt;

    // CRC chain, one stage per destination address bit
    wire [31:0] crc_chain [0:48];
    wire [5:0] hidx;
    genvar g;

    // Address decode, shared by the write and read paths
    wire sel_fcount = (reg_addr == `RXQHF_OFS_FCOUNT);
    wire sel_txreq = (reg_addr == `RXQHF_OFS_TXREQ);
    wire sel_hash0 = (reg_addr == `RXQHF_OFS_HASH0);
    wire sel_hash1 = (reg_addr == `RXQHF_OFS_HASH1);
    wire sel_hash2 = (reg_addr == `RXQHF_OFS_HASH2);
    wire sel_hash3 = (reg_addr == `RXQHF_OFS_HASH3);
    wire sel_status = (reg_addr == `RXQHF_OFS_STATUS);

    // Write enables; the captured count byte has none, it is read only
    wire wr_fcount = reg_wr && sel_fcount;
    wire wr_txreq = reg_wr && sel_txreq;
    wire wr_hash0 = reg_wr && sel_hash0;
    wire wr_hash1 = reg_wr && sel_hash1;
    wire wr_hash2 = reg_wr && sel_hash2;
    wire wr_hash3 = reg_wr && sel_hash3;
    wire wr_status = reg_wr && sel_status;

    // Write-one-to-clear requests for the two flags
    wire clr_rx = wr_status && reg_wdata[`RXQHF_BIT_RXFLAG];
    wire clr_tx = wr_status && reg_wdata[`RXQHF_BIT_TXFLAG];

    // Low byte of the live count; the register field is one byte wide
    wire [7:0] held8 = rx_frames_held[7:0];

    // Threshold crossing, compared every cycle while enabled
    wire thr_hit = threshold_enable && (held8 > rx_frame_threshold_r);

    // Either source may raise the receive flag
    wire rx_set_lvl = thr_hit || rx_frame_ready;

    // Rising edge only; a level that stays high after a clear raises nothing
    wire rx_set = rx_set_lvl && !rx_set_d_r;

    // Space check against the request; equal is enough
    wire space_ok = mem_monitor_enable && (tx_free_space >= tx_next_frames_size_r);
    wire tx_set = space_ok && !space_ok_d_r;

    // Group bit is the first bit on the wire, bit 0 of the first byte
    wire is_mcast = da_addr[0];

    // Filter qualifiers
    wire mcast_open = accept_all_enable || accept_multicast_enable;
    wire mode_is_hash = (filter_mode == `RXQHF_MODE_HASH);
    wire hash_hit = hash_table[hidx];

    // Status word as software reads it, flags at their bit positions
    wire [15:0] status_word = {2'b00, rx_flag_r, 6'h00, tx_flag_r, 6'h00};

    // Outputs come straight from flip-flops
    assign rx_flag = rx_flag_r;
    assign tx_space_flag = tx_flag_r;
    assign tx_space_request = tx_next_frames_size_r;
    assign hash_table = {hash_word3_r, hash_word2_r, hash_word1_r, hash_word0_r};

    // Receive flag next value; a set in the clear cycle wins so no event is lost
    always @* begin
        rx_flag_nxt = rx_flag_r;
        rx_frame_count_nxt = rx_frame_count_r;
        if (rx_set) begin
            rx_flag_nxt = 1'b1;
            rx_frame_count_nxt = held8;
        end else if (clr_rx) begin
            rx_flag_nxt = 1'b0;
            rx_frame_count_nxt = held8;
        end
    end

    // Space flag next value, same set-wins priority
    always @* begin
        tx_flag_nxt = tx_flag_r;
        if (tx_set) begin
            tx_flag_nxt = 1'b1;
        end else if (clr_tx) begin
            tx_flag_nxt = 1'b0;
        end
    end

    // Receive flag and its edge detector
    always @(posedge clk_sys) begin
        if (!resetn) begin
            rx_flag_r <= 1'b0;
            rx_set_d_r <= 1'b0;
        end else begin
            rx_flag_r <= rx_flag_nxt;
            rx_set_d_r <= rx_set_lvl;
        end
    end

    // Space flag and its edge detector
    always @(posedge clk_sys) begin
        if (!resetn) begin
            tx_flag_r <= 1'b0;
            space_ok_d_r <= 1'b0;
        end else begin
            tx_flag_r <= tx_flag_nxt;
            space_ok_d_r <= space_ok;
        end
    end

    // Captured count; frozen between events so software sees a stable value
    always @(posedge clk_sys) begin
        if (!resetn) begin
            rx_frame_count_r <= `RXQHF_RST_COUNT;
        end else begin
            rx_frame_count_r <= rx_frame_count_nxt;
        end
    end

    // Threshold byte; the upper byte at this offset is read only and ignored
    always @(posedge clk_sys) begin
        if (!resetn) begin
            rx_frame_threshold_r <= `RXQHF_RST_THRESH;
        end else if (wr_fcount) begin
            rx_frame_threshold_r <= reg_wdata[7:0];
        end
    end

    // Transmit space request, in 32-bit word units
    always @(posedge clk_sys) begin
        if (!resetn) begin
            tx_next_frames_size_r <= `RXQHF_RST_TXREQ;
        end else if (wr_txreq) begin
            tx_next_frames_size_r <= reg_wdata;
        end
    end

    // Table word 0, table bits 15 to 0
    always @(posedge clk_sys) begin
        if (!resetn) begin
            hash_word0_r <= `RXQHF_RST_HASH;
        end else if (wr_hash0) begin
            hash_word0_r <= reg_wdata;
        end
    end

    // Table word 1, table bits 31 to 16
    always @(posedge clk_sys) begin
        if (!resetn) begin
            hash_word1_r <= `RXQHF_RST_HASH;
        end else if (wr_hash1) begin
            hash_word1_r <= reg_wdata;
        end
    end

    // Table word 2, table bits 47 to 32
    always @(posedge clk_sys) begin
        if (!resetn) begin
            hash_word2_r <= `RXQHF_RST_HASH;
        end else if (wr_hash2) begin
            hash_word2_r <= reg_wdata;
        end
    end

    // Table word 3, table bits 63 to 48
    always @(posedge clk_sys) begin
        if (!resetn) begin
            hash_word3_r <= `RXQHF_RST_HASH;
        end else if (wr_hash3) begin
            hash_word3_r <= reg_wdata;
        end
    end

    // Read multiplexer; unmapped offsets and idle cycles read zero
    always @* begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            if (sel_fcount) begin
                rdata_nxt = {rx_frame_count_r, rx_frame_threshold_r};
            end else if (sel_txreq) begin
                rdata_nxt = tx_next_frames_size_r;
            end else if (sel_hash0) begin
                rdata_nxt = hash_word0_r;
            end else if (sel_hash1) begin
                rdata_nxt = hash_word1_r;
            end else if (sel_hash2) begin
                rdata_nxt = hash_word2_r;
            end else if (sel_hash3) begin
                rdata_nxt = hash_word3_r;
            end else if (sel_status) begin
                rdata_nxt = status_word;
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Serial CRC unrolled over the 48 address bits in wire order, no final inversion
    assign crc_chain[0] = `RXQHF_CRC_INIT;
    generate
        for (g = 0; g < 48; g = g + 1) begin : g_crc
            // Feedback bit decides whether the polynomial is folded in
            wire fb = crc_chain[g][31] ^ da_addr[g];
            assign crc_chain[g + 1] = fb ? ({crc_chain[g][30:0], 1'b0} ^ `RXQHF_CRC_POLY) : {crc_chain[g][30:0], 1'b0};
        end
    endgenerate

    // Index from the six most significant bits; long path, one address per cycle
    assign hidx = crc_chain[48][31:26];

    // Filter verdict; only group frames in hash mode can be dropped
    always @* begin
        da_accept_nxt = 1'b0;
        da_drop_nxt = 1'b0;
        if (da_valid) begin
            if (!is_mcast) begin
                da_accept_nxt = 1'b1;
            end else if (mcast_open) begin
                da_accept_nxt = 1'b1;
            end else if (mode_is_hash) begin
                if (hash_hit) begin
                    da_accept_nxt = 1'b1;
                end else begin
                    da_drop_nxt = 1'b1;
                end
            end else begin
                da_accept_nxt = 1'b1;
            end
        end
    end

    // Verdict outputs registered one cycle after da_valid
    always @(posedge clk_sys) begin
        if (!resetn) begin
            da_done <= 1'b0;
            da_accept <= 1'b0;
            da_drop <= 1'b0;
        end else begin
            da_done <= da_valid;
            da_accept <= da_accept_nxt;
            da_drop <= da_drop_nxt;
        end
    end

endmodule // rxqhf_core

// File: verif/rxqhf_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module rxqhf_host (
    input wire clk_sys,
    output reg [7:0] reg_addr = 0,
    output reg [15:0] reg_wdata = 0,
    output reg reg_wr = 0,
    output reg reg_rd = 0
);
    // One-cycle strobes; released data is inverted so stale data never looks valid
    task wr(input [7:0] a, input [15:0] d); begin
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        {reg_wdata, reg_wr} <= {~d, 1'b0};
    end endtask
    task rd(input [7:0] a); begin
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    end endtask
endmodule // rxqhf_host

// File: verif/rxqhf_core_sva.sv
// Port assertions for the queue count and hash filter block
`timescale 1ns/1ps
module rxqhf_core_sva (
    input wire clk_sys,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire [2:0] filter_mode,
    input wire accept_all_enable,
    input wire accept_multicast_enable,
    input wire da_valid,
    input wire [47:0] da_addr,
    input wire da_done,
    input wire da_accept,
    input wire da_drop,
    input wire rx_flag,
    input wire tx_space_flag,
    input wire [15:0] tx_space_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Status write; clears only with a one in the flag bit
    wire clr = reg_wr && reg_addr == 8'h92;
    a_da_answer: assert property (da_valid |=> da_done && da_accept != da_drop) else $error("no verdict");
    a_da_quiet: assert property (!da_valid |=> !da_done) else $error("spurious verdict");
    a_unicast_pass: assert property (da_valid && !da_addr[0] |=> da_accept) else $error("unicast lost");
    a_mode_pass: assert property (da_valid && filter_mode != 3'h5 |=> da_accept) else $error("mode");
    a_mc_all: assert property (da_valid && (accept_all_enable || accept_multicast_enable) |=> da_accept)
        else $error("multicast lost");
    a_txreq_write: assert property (reg_wr && reg_addr == 8'h9e |=> tx_space_request == $past(reg_wdata))
        else $error("tx request");
    a_rx_hold: assert property (rx_flag && !(clr && reg_wdata[13]) |=> rx_flag) else $error("rx flag");
    a_tx_hold: assert property (tx_space_flag && !(clr && reg_wdata[6]) |=> tx_space_flag) else $error("tx");
endmodule // rxqhf_core_sva
bind rxqhf_core rxqhf_core_sva i_rxqhf_core_sva (.*);

// File: verif/rxqhf_core_test.sv
// Self-checking bench for the queue count and hash filter block
`timescale 1ns/1ps
module rxqhf_core_test;
    reg clk_sys = 0, resetn = 0, rx_frame_ready = 0, threshold_enable = 0, mem_monitor_enable = 0;
    reg accept_all_enable = 0, accept_multicast_enable = 0, da_valid = 0, rd_seen = 0;
    reg [7:0] rx_frames_held = 0;
    reg [15:0] tx_free_space = 0, eq[$];
    reg [2:0] filter_mode = 0;
    reg [47:0] da_addr = 0;
    reg [63:0] ht = 0;
    reg dq[$];
    wire [7:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata, tx_space_request;
    wire reg_wr, reg_rd, da_done, da_accept, da_drop, rx_flag, tx_space_flag;
    integer mismatches = 0, num_checks = 0, seed = 32'hd9c8, i;
    always #25 clk_sys = ~clk_sys;
    rxqhf_host i_rxqhf_host (.*);
    rxqhf_core i_rxqhf_core (.*);
    task chk_reg(input [15:0] e); begin
        num_checks = num_checks + 1;
        if (reg_rdata !== e) begin
            mismatches = mismatches + 1;
            $display("unexpected reg_rdata exp %h got %h", e, reg_rdata);
        end
    end endtask
    task chk_da(input e); begin
        num_checks = num_checks + 1;
        if ({da_accept, da_drop} !== {e, !e}) begin
            mismatches = mismatches + 1;
            $display("unexpected da_accept exp %b got %b", e, da_accept);
        end
    end endtask
    // Hash index, LSB of each byte first
    function [5:0] idx(input [47:0] a);
        reg [31:0] c;
        integer k;
        begin
            c = 32'hffff_ffff;
            for (k = 0; k < 48; k = k + 1) c = {c[30:0], 1'b0} ^ ((c[31] ^ a[k]) ? 32'h04c1_1db7 : 32'h0);
            idx = c[31:26];
        end
    endfunction
    task rd(input [7:0] a, input [15:0] e); begin
        eq.push_back(e);
        i_rxqhf_host.rd(a);
    end endtask
    task da(input [47:0] a); begin
        @(posedge clk_sys);
        {da_addr, da_valid} <= {a, 1'b1};
        dq.push_back(!a[0] || filter_mode != 3'h5 || accept_all_enable || accept_multicast_enable || ht[idx(a)]);
        @(posedge clk_sys);
        da_valid <= 1'b0;
    end endtask
    // Monitor on the falling edge, where registered answers are settled
    always @(negedge clk_sys) begin
        if (rd_seen) chk_reg(eq.pop_front());
        if (da_done) chk_da(dq.pop_front());
        rd_seen = reg_rd;
    end
    task complete_run; begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches = mismatches + 1;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 8; i = i + 1) rd(8'h9c + 2 * i, 16'h0000);
        $display("reset values done");
        rx_frames_held <= 8'd3;
        i_rxqhf_host.wr(8'h9c, 16'hff02);
        threshold_enable <= 1'b1;
        repeat (8) if (rx_flag !== 1'b1) @(posedge clk_sys);
        rd(8'h92, 16'h2000);
        rd(8'h9c, 16'h0302);
        threshold_enable <= 1'b0;
        rx_frames_held <= 8'd5;
        i_rxqhf_host.wr(8'h92, 16'h2000);
        rd(8'h9c, 16'h0502);
        rd(8'h92, 16'h0000);
        rx_frame_ready <= 1'b1;
        repeat (8) if (rx_flag !== 1'b1) @(posedge clk_sys);
        rd(8'h92, 16'h2000);
        i_rxqhf_host.wr(8'h92, 16'h2000);
        $display("frame count done");
        tx_free_space <= 16'h003f;
        i_rxqhf_host.wr(8'h9e, 16'h0040);
        mem_monitor_enable <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(8'h92, 16'h0000);
        tx_free_space <= 16'h0040;
        repeat (8) if (tx_space_flag !== 1'b1) @(posedge clk_sys);
        rd(8'h92, 16'h0040);
        $display("tx space done");
        for (i = 0; i < 4; i = i + 1) begin
            ht[16 * i +: 16] = $random(seed);
            i_rxqhf_host.wr(8'ha0 + 2 * i, ht[16 * i +: 16]);
        end
        for (i = 0; i < 300; i = i + 1) begin
            @(posedge clk_sys);
            filter_mode <= ($random(seed) & 1) ? 3'h5 : $random(seed);
            {accept_all_enable, accept_multicast_enable} <= ($random(seed) % 6 == 0) ? $random(seed) : 0;
            da({$random(seed), $random(seed)} | (($random(seed) & 3) ? 48'h0000_0000_0001 : 0));
        end
        $display("hash filter done");
        repeat (3) @(posedge clk_sys);
        complete_run;
    end
endmodule // rxqhf_core_test
